/* File: pm_pkg.sv */
// constants, types and helpers of the power-mode controller
// assumes a single pclk domain at 20 MHz
package pm_pkg;
    // clock and timing
    localparam int PCLK_NS = 50;
    localparam int CPU_DLY_NS = 2000;
    localparam int TIOBST_NS = 1000;
    localparam int OSC_WAIT_CYC = 1024;
    localparam int CPU_DLY_CYC = (CPU_DLY_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int TIOBST_CYC = (TIOBST_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int TMR_W = 11;
    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] IEN_OFS = 8'h08;
    // control fields
    localparam int IDLE_BIT = 0;
    localparam int CSS_LSB = 1;
    localparam int SECEN_BIT = 3;
    localparam int IFS_LSB = 4;
    localparam int LFSS_BIT = 7;
    localparam int GLB_IRQ_BIT = 8;
    localparam int TWOSPD_BIT = 9;
    localparam int FSCM_BIT = 10;
    localparam int WDTEN_BIT = 11;
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [7:0] IEN_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_IDLE = 3'b011,
        ST_WAKE = 3'b100
    } state_e;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_PRI = 2'b01,
        SRC_SEC = 2'b10,
        SRC_INT = 2'b11
    } src_e;

    // run/idle source chosen by clock_source_select; bit 0 ignored when bit 1 set
    function automatic src_e src_of(input logic [1:0] css);
        if (css[1]) begin
            return SRC_INT;
        end
        return css[0] ? SRC_SEC : SRC_PRI;
    endfunction
endpackage

/* File: pm_reg_if.sv */
// control and status carried between register slave and mode controller
// assumes both ends sit on pclk
`timescale 1ns/10ps
interface pm_reg_if;
    logic idle_on_sleep_select;
    logic [1:0] clock_source_select;
    logic secondary_osc_enable;
    logic [2:0] internal_freq_select;
    logic low_freq_source_select;
    logic global_interrupt_enable;
    logic two_speed_en;
    logic fail_safe_en;
    logic watchdog_en;
    logic [7:0] peripheral_irq_enable_reg;
    logic ifs_wr;
    logic [7:0] status;

    modport regs (
        output idle_on_sleep_select, clock_source_select, secondary_osc_enable,
        output internal_freq_select, low_freq_source_select, global_interrupt_enable,
        output two_speed_en, fail_safe_en, watchdog_en, peripheral_irq_enable_reg, ifs_wr,
        input status
    );
    modport core (
        input idle_on_sleep_select, clock_source_select, secondary_osc_enable,
        input internal_freq_select, low_freq_source_select, global_interrupt_enable,
        input two_speed_en, fail_safe_en, watchdog_en, peripheral_irq_enable_reg, ifs_wr,
        output status
    );
endinterface

/* File: cycle_timer.sv */
// down-counting delay timer; done once armed and expired
// assumes load and clr are pulses or levels on pclk
`timescale 1ns/10ps
module cycle_timer #(
    parameter int W = 11
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic load,
    input wire logic clr,
    input wire logic [W-1:0] len,
    // status
    output logic done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic armed_reg;
    logic armed_next;

    always_comb begin
        cnt_next = cnt_reg;
        armed_next = armed_reg;
        if (clr) begin
            armed_next = 1'b0;
            cnt_next = '0;
        end else if (load) begin
            armed_next = 1'b1;
            cnt_next = len;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            armed_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            armed_reg <= armed_next;
        end
    end

    assign done = armed_reg && (cnt_reg == '0) && !load;
endmodule

/* File: pm_apb_regs.sv */
// apb slave holding control, interrupt enables and status view
// assumes zero-wait apb master on pclk
`timescale 1ns/10ps
module pm_apb_regs (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // controller side
    pm_reg_if.regs bus
);
    logic [11:0] ctrl_reg;
    logic [11:0] ctrl_next;
    logic [7:0] ien_reg;
    logic [7:0] ien_next;
    logic [31:0] rd_reg;
    logic [31:0] rd_next;
    logic err_reg;
    logic err_next;
    logic wr_en;
    logic hit;

    assign hit = (paddr == pm_pkg::CTRL_OFS) || (paddr == pm_pkg::STAT_OFS)
        || (paddr == pm_pkg::IEN_OFS);
    assign wr_en = psel && penable && pwrite;

    always_comb begin
        ctrl_next = ctrl_reg;
        ien_next = ien_reg;
        rd_next = rd_reg;
        err_next = err_reg;
        // only software writes touch control; wake-ups never do
        if (wr_en && paddr == pm_pkg::CTRL_OFS) begin
            ctrl_next = pwdata[11:0]; // R3
        end
        if (wr_en && paddr == pm_pkg::IEN_OFS) begin
            ien_next = pwdata[7:0];
        end
        // read data latched in setup phase
        if (psel && !penable) begin
            err_next = !hit;
            unique case (paddr)
                pm_pkg::CTRL_OFS: rd_next = {20'h0_0000, ctrl_reg};
                pm_pkg::STAT_OFS: rd_next = {24'h00_0000, bus.status};
                pm_pkg::IEN_OFS: rd_next = {24'h00_0000, ien_reg};
                default: rd_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= pm_pkg::CTRL_RST;
            ien_reg <= pm_pkg::IEN_RST;
            rd_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            ien_reg <= ien_next;
            rd_reg <= rd_next;
            err_reg <= err_next;
        end
    end

    assign prdata = rd_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_reg;
    assign bus.idle_on_sleep_select = ctrl_reg[pm_pkg::IDLE_BIT];
    assign bus.clock_source_select = ctrl_reg[pm_pkg::CSS_LSB +: 2];
    assign bus.secondary_osc_enable = ctrl_reg[pm_pkg::SECEN_BIT];
    assign bus.internal_freq_select = ctrl_reg[pm_pkg::IFS_LSB +: 3];
    assign bus.low_freq_source_select = ctrl_reg[pm_pkg::LFSS_BIT];
    assign bus.global_interrupt_enable = ctrl_reg[pm_pkg::GLB_IRQ_BIT];
    assign bus.two_speed_en = ctrl_reg[pm_pkg::TWOSPD_BIT];
    assign bus.fail_safe_en = ctrl_reg[pm_pkg::FSCM_BIT];
    assign bus.watchdog_en = ctrl_reg[pm_pkg::WDTEN_BIT];
    assign bus.peripheral_irq_enable_reg = ien_reg;
    assign bus.ifs_wr = wr_en && (paddr == pm_pkg::CTRL_OFS)
        && (pwdata[pm_pkg::IFS_LSB +: 3] != ctrl_reg[pm_pkg::IFS_LSB +: 3]);

    AST_CTRL_KEPT: assert property (@(posedge pclk) disable iff (!presetn) // R3
        !wr_en |=> $stable(ctrl_reg))
        else $error("control changed without a write");
endmodule

/* File: pm_mode_ctrl.sv */
// power-mode controller: sleep/idle entry, clock gating, wake sequencing
// assumes core, watchdog and clock_lost drive single-cycle pulses on pclk; secondary_osc_started is a level
//
// Notes on behaviour
// [R1] sleep stops selected oscillator, clears all status flags, no switch; secondary keeps running while secondary_osc_enable set
// [R2] wake from sleep waits for primary, or runs internal if two-speed/fail-safe
// [R3] wake-up never alters idle select or clock source select
// [R4] idle entry stops cpu clock only; peripherals keep selected source
// [R5] idle exits on interrupt, watchdog or reset, cpu waits start delay
// [R6] watchdog time-out in sleep or idle wakes into selected run mode
// [R7] primary idle keeps primary clock and its ready flag
// [R8] wake from primary idle resumes on primary after start delay
// [R9] secondary idle: peripherals on secondary, primary off, flags swap
// [R10] secondary idle sleep ignored when secondary oscillator disabled
// [R11] peripheral clocks held until secondary oscillator has started
// [R12] wake from secondary idle stays on secondary oscillator
// [R13] mode_a selected by bit 1, primary stops, ready flag clears
// [R14] fast internal oscillator enabled by nonzero freq or low-freq select
// [R15] stable flag held if already stable, clear when oscillator off
// [R16] wake from mode_a stays internal; rc runs for watchdog or fail-safe
// [R17] enabled interrupt flag starts exit at once
// [R18] branch to vector after interrupt wake only if global enable set
// [R19] watchdog time-out while running gives watchdog reset
// [R20] watchdog cleared on sleep, clear instruction, clock loss, freq write
// [R21] reset exit held until primary ready, then ready flag, then run
// [R22] two-speed/fail-safe run internal at once; sleep first shuts primary
// [R23] ready flag means primary drives, running flag means secondary
// [R24] start delay, settle time and start-up wait are cycle counts
`timescale 1ns/10ps
module pm_mode_ctrl #(
    parameter int CPU_DLY_CYCLES = pm_pkg::CPU_DLY_CYC,
    parameter int TIOBST_CYCLES = pm_pkg::TIOBST_CYC,
    parameter int OSC_WAIT_CYCLES = pm_pkg::OSC_WAIT_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core and watchdog events
    input wire logic sleep_exec,
    input wire logic watchdog_clear_instruction,
    input wire logic wdt_timeout,
    input wire logic [7:0] irq_flags,
    // oscillator status
    input wire logic secondary_osc_started,
    input wire logic clock_lost,
    // clock control
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic [1:0] clk_src,
    output logic primary_osc_en,
    output logic secondary_osc_run,
    output logic fast_osc_en,
    output logic low_freq_rc_en,
    // status
    output logic primary_clock_ready_flag,
    output logic internal_osc_stable_flag,
    output logic secondary_clock_running_flag,
    output logic device_in_reset,
    // core sequencing pulses
    output logic resume,
    output logic branch_to_vector,
    output logic watchdog_clear,
    output logic watchdog_reset
);
    pm_reg_if bus ();

    pm_pkg::state_e state_reg;
    pm_pkg::state_e state_next;
    pm_pkg::src_e src_reg;
    pm_pkg::src_e src_next;
    pm_pkg::src_e tgt;
    logic pri_on_reg;
    logic pri_on_next;
    logic pend_reg;
    logic pend_next;
    logic wake_irq_reg;
    logic wake_irq_next;
    logic resume_reg;
    logic resume_next;
    logic branch_reg;
    logic branch_next;
    logic wdt_clr_reg;
    logic wdt_clr_next;
    logic wdt_rst_reg;
    logic wdt_rst_next;
    logic int_en_reg;
    logic dly_ld;
    logic dly_done;
    logic pri_up;
    logic int_en;
    logic int_stable;
    logic irq_hit;
    logic wake_ev;
    logic fast_start;

    pm_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus.regs)
    );

    // delays held as cycle counts
    cycle_timer #(.W(pm_pkg::TMR_W)) u_cpu_dly ( // R24
        .pclk(pclk),
        .presetn(presetn),
        .load(dly_ld),
        .clr(1'b0),
        .len(pm_pkg::TMR_W'(CPU_DLY_CYCLES)),
        .done(dly_done)
    );

    // primary start-up wait, restarted when the primary is switched on
    cycle_timer #(.W(pm_pkg::TMR_W)) u_osc_wait (
        .pclk(pclk),
        .presetn(presetn),
        .load(pri_on_next && !pri_on_reg),
        .clr(!pri_on_reg && !pri_on_next),
        .len(pm_pkg::TMR_W'(OSC_WAIT_CYCLES)),
        .done(pri_up)
    );

    // internal oscillator settling; flag stays if already stable
    cycle_timer #(.W(pm_pkg::TMR_W)) u_settle ( // R14
        .pclk(pclk),
        .presetn(presetn),
        .load(int_en && !int_en_reg),
        .clr(!int_en), // R15
        .len(pm_pkg::TMR_W'(TIOBST_CYCLES)),
        .done(int_stable)
    );

    assign irq_hit = |(irq_flags & bus.peripheral_irq_enable_reg); // R17
    assign wake_ev = irq_hit || wdt_timeout; // R5 R6
    assign fast_start = bus.two_speed_en || bus.fail_safe_en;
    assign tgt = pm_pkg::src_of(bus.clock_source_select); // R13
    assign int_en = (src_reg == pm_pkg::SRC_INT)
        && ((bus.internal_freq_select != 3'h0) || bus.low_freq_source_select); // R14

    always_comb begin
        state_next = state_reg;
        src_next = src_reg;
        pri_on_next = pri_on_reg;
        pend_next = pend_reg;
        wake_irq_next = wake_irq_reg;
        resume_next = 1'b0;
        branch_next = 1'b0;
        wdt_rst_next = 1'b0;
        dly_ld = 1'b0;
        wdt_clr_next = watchdog_clear_instruction
            || (bus.fail_safe_en && clock_lost)
            || (bus.ifs_wr && src_reg == pm_pkg::SRC_INT); // R20
        unique case (state_reg)
            pm_pkg::ST_RESET: begin
                pri_on_next = 1'b1;
                if (fast_start) begin
                    state_next = pm_pkg::ST_RUN; // R22
                    src_next = pm_pkg::SRC_INT;
                    pend_next = 1'b1;
                end else if (pri_up) begin
                    state_next = pm_pkg::ST_RUN; // R21
                    src_next = pm_pkg::SRC_PRI;
                end
            end
            pm_pkg::ST_RUN: begin
                if (pend_reg && pri_up) begin
                    src_next = pm_pkg::SRC_PRI; // R22
                    pend_next = 1'b0;
                end
                if (wdt_timeout) begin
                    wdt_rst_next = 1'b1; // R19
                    state_next = pm_pkg::ST_RESET;
                    src_next = pm_pkg::SRC_NONE;
                    pri_on_next = 1'b0;
                    pend_next = 1'b0;
                end else if (sleep_exec) begin
                    wdt_clr_next = 1'b1; // R20
                    if (!bus.idle_on_sleep_select) begin
                        state_next = pm_pkg::ST_SLEEP; // R1
                        src_next = pm_pkg::SRC_NONE;
                        pri_on_next = 1'b0;
                        pend_next = 1'b0;
                    end else if (tgt != pm_pkg::SRC_SEC || bus.secondary_osc_enable) begin // R10
                        state_next = pm_pkg::ST_IDLE; // R4
                        src_next = tgt; // R7 R9 R13
                        pri_on_next = (tgt == pm_pkg::SRC_PRI); // R9 R13 R22
                        pend_next = 1'b0;
                    end
                end
            end
            pm_pkg::ST_SLEEP, pm_pkg::ST_IDLE: begin
                if (wake_ev) begin
                    state_next = pm_pkg::ST_WAKE; // R5
                    dly_ld = 1'b1;
                    wake_irq_next = irq_hit;
                    if (state_reg == pm_pkg::ST_SLEEP) begin
                        src_next = tgt; // R6
                        if (tgt == pm_pkg::SRC_PRI) begin
                            pri_on_next = 1'b1; // R2
                            if (fast_start) begin
                                src_next = pm_pkg::SRC_INT;
                                pend_next = 1'b1;
                            end
                        end
                    end
                end
            end
            pm_pkg::ST_WAKE: begin
                // idle source kept; primary must be up only when running on primary
                if (dly_done && (src_reg != pm_pkg::SRC_PRI || pri_up)) begin
                    state_next = pm_pkg::ST_RUN; // R8 R12 R16
                    resume_next = 1'b1;
                    branch_next = wake_irq_reg && bus.global_interrupt_enable; // R18
                end
            end
            default: begin
                state_next = pm_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= pm_pkg::ST_RESET;
            src_reg <= pm_pkg::SRC_NONE;
            pri_on_reg <= 1'b0;
            pend_reg <= 1'b0;
            wake_irq_reg <= 1'b0;
            resume_reg <= 1'b0;
            branch_reg <= 1'b0;
            wdt_clr_reg <= 1'b0;
            wdt_rst_reg <= 1'b0;
            int_en_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            src_reg <= src_next;
            pri_on_reg <= pri_on_next;
            pend_reg <= pend_next;
            wake_irq_reg <= wake_irq_next;
            resume_reg <= resume_next;
            branch_reg <= branch_next;
            wdt_clr_reg <= wdt_clr_next;
            wdt_rst_reg <= wdt_rst_next;
            int_en_reg <= int_en;
        end
    end

    // clock gating and status from the registered mode
    assign cpu_clk_en = (state_reg == pm_pkg::ST_RUN); // R4
    assign periph_clk_en = (state_reg != pm_pkg::ST_RESET)
        && (state_reg != pm_pkg::ST_SLEEP)
        && (src_reg != pm_pkg::SRC_NONE)
        && (src_reg != pm_pkg::SRC_SEC || secondary_osc_started) // R11
        && (src_reg != pm_pkg::SRC_PRI || pri_up); // R2
    assign clk_src = src_reg;
    assign primary_osc_en = pri_on_reg;
    assign secondary_osc_run = bus.secondary_osc_enable; // R1 R12
    assign fast_osc_en = int_en;
    assign low_freq_rc_en = bus.watchdog_en || bus.fail_safe_en // R1 R16
        || (src_reg == pm_pkg::SRC_INT && !int_en);
    assign primary_clock_ready_flag = (src_reg == pm_pkg::SRC_PRI) && pri_up; // R23
    assign secondary_clock_running_flag = (src_reg == pm_pkg::SRC_SEC); // R9 R23
    assign internal_osc_stable_flag = int_stable && int_en; // R1 R15
    assign device_in_reset = (state_reg == pm_pkg::ST_RESET); // R21
    assign resume = resume_reg;
    assign branch_to_vector = branch_reg;
    assign watchdog_clear = wdt_clr_reg;
    assign watchdog_reset = wdt_rst_reg;
    assign bus.status = {periph_clk_en, cpu_clk_en, state_reg,
        secondary_clock_running_flag, internal_osc_stable_flag, primary_clock_ready_flag};

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_idle_wake;
        state_reg == pm_pkg::ST_IDLE && wake_ev;
    endsequence
    sequence s_run_sleep;
        state_reg == pm_pkg::ST_RUN && sleep_exec && !wdt_timeout;
    endsequence

    AST_SLEEP_FLAGS: assert property ( // R1
        state_reg == pm_pkg::ST_SLEEP |-> !primary_clock_ready_flag
            && !secondary_clock_running_flag && !internal_osc_stable_flag && !primary_osc_en)
        else $error("status flag or primary set in sleep");
    AST_START_WAIT: assert property ( // R5
        s_idle_wake |=> (state_reg == pm_pkg::ST_WAKE && !cpu_clk_en)[*2])
        else $error("cpu resumed before start delay");
    AST_SEC_IGNORED: assert property ( // R10
        s_run_sleep ##0 (bus.idle_on_sleep_select && bus.clock_source_select == 2'b01
            && !bus.secondary_osc_enable) |=> state_reg == pm_pkg::ST_RUN)
        else $error("secondary idle entered with oscillator disabled");
    AST_SEC_HOLD: assert property ( // R11
        src_reg == pm_pkg::SRC_SEC && !secondary_osc_started |-> !periph_clk_en)
        else $error("peripheral clock before secondary start");
    AST_WDT_RESET: assert property ( // R19
        state_reg == pm_pkg::ST_RUN && wdt_timeout |=> watchdog_reset && device_in_reset)
        else $error("watchdog in run did not reset");
    AST_WDT_WAKE: assert property ( // R6
        state_reg == pm_pkg::ST_SLEEP && wdt_timeout
            |=> state_reg == pm_pkg::ST_WAKE && !watchdog_reset)
        else $error("watchdog in sleep did not wake");
    AST_WDT_CLR: assert property ( // R20
        s_run_sleep |=> watchdog_clear)
        else $error("watchdog not cleared on sleep");
    AST_BRANCH: assert property ( // R18
        branch_to_vector |-> resume && $past(wake_irq_reg)
            && $past(bus.global_interrupt_enable))
        else $error("vector branch without interrupt wake and global enable");
    AST_PRIMARY_IDLE_MODE: assert property ( // R7
        state_reg == pm_pkg::ST_IDLE && src_reg == pm_pkg::SRC_PRI && $past(pri_up)
            |-> primary_clock_ready_flag && periph_clk_en)
        else $error("primary idle lost primary clock");
    AST_IRQ_WAKE: assert property ( // R17
        state_reg == pm_pkg::ST_IDLE && irq_hit |=> state_reg == pm_pkg::ST_WAKE && wake_irq_reg)
        else $error("enabled interrupt did not start exit");
endmodule

/* File: sec_osc_model.sv */
// secondary oscillator model: reports started some cycles after enable
// assumes the enable comes from the controller on pclk
`timescale 1ns/10ps
module sec_osc_model #(
    parameter int START = 5
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // oscillator
    input wire logic run,
    output logic started
);
    int cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
        end else begin
            cnt <= !run ? 0 : (cnt < START) ? cnt + 1 : cnt;
        end
    end
    assign started = (cnt == START);
endmodule

/* File: tb_top.sv */
// self-checking bench for the power-mode controller
// assumes pm_pkg is compiled first; timing counts are shortened
`timescale 1ns/10ps
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se, sec_ok;
    logic [7:0] paddr = 0, irq = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0] evs = 0;
    logic pready, cpu, per, pri_en, fast, lfrc, pri_f, int_f, sec_f, in_rst, res, vec;
    logic wclr, wrst, secondary_run_mode, rd_err, lost = 0;
    logic [1:0] src;
    int error_cnt = 0, n_tests = 0, n;

    always #25 pclk = ~pclk;

    pm_mode_ctrl #(.CPU_DLY_CYCLES(3), .TIOBST_CYCLES(3), .OSC_WAIT_CYCLES(4)) pm_mode_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(se),
        .sleep_exec(evs[0]), .watchdog_clear_instruction(evs[1]), .wdt_timeout(evs[2]),
        .irq_flags(irq), .secondary_osc_started(sec_ok), .clock_lost(lost),
        .cpu_clk_en(cpu), .periph_clk_en(per), .clk_src(src), .primary_osc_en(pri_en),
        .secondary_osc_run(secondary_run_mode), .fast_osc_en(fast), .low_freq_rc_en(lfrc),
        .primary_clock_ready_flag(pri_f), .internal_osc_stable_flag(int_f),
        .secondary_clock_running_flag(sec_f), .device_in_reset(in_rst), .resume(res),
        .branch_to_vector(vec), .watchdog_clear(wclr), .watchdog_reset(wrst));

    sec_osc_model #(.START(5)) sec_osc_model_i (
        .pclk(pclk), .presetn(presetn), .run(secondary_run_mode), .started(sec_ok));

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            error_cnt++;
            wrap_up();
        end
        rd = prdata;
        rd_err = se;
        psel <= 0;
        penable <= 0;
    endtask

    // one-cycle event pulse on sleep, clear or time-out; look just after it lands
    task automatic fire(input logic [2:0] v);
        @(posedge pclk);
        evs <= v;
        @(posedge pclk);
        evs <= 3'h0;
        #1;
    endtask

    // wait for resume (0) or cpu clock (1); n counts the edges
    task automatic wt(input int which);
        n = 0;
        while (((which == 0) ? res : cpu) !== 1'b1) begin
            @(posedge pclk);
            #1;
            n++;
            if (n > 200) begin
                error_cnt++;
                wrap_up();
            end
        end
    endtask

    task automatic irq_wake();
        @(posedge pclk);
        irq <= 8'h01;
        @(posedge pclk);
        irq <= 8'h00;
        wt(0);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        wt(1);
        chk("ready after reset", 1, pri_f);
        chk("source after reset", 1, src);
        apb(0, 8'h0c, 0);
        chk("unmapped read", 0, rd);
        chk("unmapped error", 1, rd_err);
        apb(1, pm_pkg::IEN_OFS, 32'h0000_0001);
        apb(1, pm_pkg::CTRL_OFS, 32'h0000_0001);
        fire(3'b001);
        chk("clear on sleep", 1, wclr);
        chk("cpu in idle", 0, cpu);
        chk("periph in idle", 1, per);
        chk("ready in idle", 1, pri_f);
        irq_wake();
        chk("start delay", 4, n);
        chk("no vector", 0, vec);
        chk("ready after wake", 1, pri_f);
        apb(0, pm_pkg::CTRL_OFS, 0);
        chk("control kept", 32'h0000_0001, rd);
        apb(1, pm_pkg::CTRL_OFS, 32'h0000_0003);
        fire(3'b001);
        chk("refused idle", 1, cpu);
        apb(1, pm_pkg::CTRL_OFS, 32'h0000_010b);
        fire(3'b001);
        chk("sec held", 0, per);
        repeat (4) @(posedge pclk);
        #1;
        chk("sec started", 1, per);
        chk("sec running", 1, sec_f);
        chk("ready cleared", 0, pri_f);
        irq_wake();
        chk("vector", 1, vec);
        chk("sec kept", 2'b10, src);
        apb(1, pm_pkg::CTRL_OFS, 32'h0000_0017);
        repeat (8) @(posedge pclk);
        fire(3'b001);
        chk("fast osc on", 1, fast);
        chk("primary off", 0, pri_f);
        repeat (6) @(posedge pclk);
        chk("stable flag", 1, int_f);
        fire(3'b100);
        wt(0);
        chk("no reset", 0, in_rst);
        chk("internal kept", 2'b11, src);
        apb(1, pm_pkg::CTRL_OFS, 32'h0000_0800);
        repeat (12) @(posedge pclk);
        fire(3'b001);
        #1;
        chk("flags cleared", 0, {pri_f, int_f, sec_f});
        chk("primary stopped", 0, pri_en);
        chk("rc kept for watchdog", 1, lfrc);
        fire(3'b100);
        wt(0);
        chk("primary wait", 5, n);
        chk("ready on wake", 1, pri_f);
        apb(1, pm_pkg::CTRL_OFS, 32'h0000_0c00);
        fire(3'b001);
        fire(3'b100);
        wt(0);
        chk("internal first", 2'b11, src);
        @(posedge pclk);
        lost <= 1'b1;
        @(posedge pclk);
        lost <= 1'b0;
        #1;
        chk("clear on clock loss", 1, wclr);
        fire(3'b100);
        chk("wd reset", 1, wrst);
        chk("held in reset", 1, in_rst);
        wt(1);
        fire(3'b010);
        chk("clear instr", 1, wclr);
        wrap_up();
    end
endmodule
